// File: tmr_map.svh
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// register indices; byte address is four times the index
`define TMR_IDX_TICK_COUNT 8'h01
`define TMR_IDX_IRQ_CONTROL 8'h0b
`define TMR_IDX_OPTION_CONFIG 8'h81
`define TMR_IDX_PORT_A_DIRECTION 8'h85
`define TMR_IDX_EVT_STATUS 8'h90
`define TMR_IDX_EVT_ENABLE 8'h91
`define TMR_IDX_EVT_CLEAR 8'h92
`define TMR_IDX_CORE_CTRL 8'h93
`define TMR_IDX_CORE_CMD 8'h94

// reset values
`define TMR_RST_TICK_COUNT 8'h00
`define TMR_RST_IRQ_CONTROL 8'h00
`define TMR_RST_OPTION_CONFIG 8'hff
`define TMR_RST_PORT_A_DIRECTION 6'h3f

// option_config fields
`define TMR_OPT_SOURCE_SELECT 5
`define TMR_OPT_EDGE_SELECT 4
`define TMR_OPT_SCALER_ASSIGN 3
`define TMR_OPT_RATIO_HI 2
`define TMR_OPT_RATIO_LO 0

// irq_control fields
`define TMR_IRQ_OVF_ENABLE 5
`define TMR_IRQ_OVF_FLAG 2

// event status, enable and clear fields
`define TMR_EVT_OVERFLOW 0
`define TMR_EVT_WDT_TICK 1
`define TMR_EVT_WIDTH 2

// core control and command fields
`define TMR_CTRL_SLEEP 0
`define TMR_CMD_WDT_CLEAR 0

// timing: one instruction cycle is four clocks, write holds off two cycles
`define TMR_ICYC_CLOCKS 3'd4
`define TMR_WRITE_INHIBIT 2'd2
`define TMR_COUNT_MAX 8'hff

`endif

// File: tmr_pkg.sv
package tmr_pkg;

  // bus slave phase
  typedef enum logic [0:0] {
    TMR_BUS_IDLE = 1'b0,
    TMR_BUS_DATA = 1'b1
  } tmr_bus_st_t;

  // prescaler owner, as coded by the scaler assign bit
  typedef enum logic [0:0] {
    TMR_PRE_COUNTER = 1'b0,
    TMR_PRE_WATCHDOG = 1'b1
  } tmr_pre_user_t;

endpackage

// File: tmr_top.sv
// Functional notes
// - timer mode counts every instruction cycle
// - counter write blocks counting two instruction cycles
// - counter mode counts external pin edges
// - edge select: clear rising, set falling
// - external pin synchronised before counting
// - one 8-bit prescaler, counter or watchdog
// - prescaler count hidden from software
// - counter prescale ratios 1:2 to 1:256
// - watchdog prescale ratios 1:1 to 1:128
// - counter write clears prescaler when the counter owns it, keeps assignment
// - watchdog clear also clears prescaler when the watchdog owns it
// - assignment may change at any time
// - rollover FFh to 00h sets overflow flag
// - enable bit masks request, flag still sets
// - timer stopped during sleep
`include "tmr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module tmr_top (
  input wire logic hclk, // clock, 20 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic ext_count_pin, // external count input
  input wire logic wdt_base_tick, // watchdog time base pulse
  output logic wdt_tick, // prescaled watchdog tick
  output logic wdt_clear, // watchdog clear pulse
  output logic overflow_irq, // overflow flag and enable
  output logic irq, // enabled event pending
  output logic [5:0] port_a_direction // port a direction bits
);

  // bus side: phase, captured address phase and write strobes
  tmr_pkg::tmr_bus_st_t bus_st;
  logic addr_take;
  logic [7:0] cur_idx;
  logic cur_write;
  logic cur_hit;
  logic wr_en;
  logic [7:0] wr_byte;
  logic [7:0] rd_val;
  logic wr_option;
  logic wr_dir;
  logic wr_enable;
  logic wr_ctrl;
  logic wr_irqctl;
  logic wr_evtclr;

  // software visible registers
  logic [7:0] tick_count_reg;
  logic [7:0] irq_control_reg;
  logic [7:0] option_config;
  logic [`TMR_EVT_WIDTH-1:0] evt_status;
  logic [`TMR_EVT_WIDTH-1:0] evt_enable;
  logic sleep_mode;

  // instruction cycle timing and pin history
  logic [2:0] div_cnt;
  logic icyc_en;
  logic ext_s1;
  logic ext_s2;
  logic ext_s3;
  logic ext_edge;

  // counting path and shared prescaler
  logic [1:0] inhibit_cnt;
  logic [7:0] prescaler;
  logic [7:0] pre_mask;
  logic pre_evt;
  logic pre_hit;
  logic src_evt;
  logic cnt_step;
  logic ovf_evt;
  logic wdt_evt;
  logic tick_write;
  logic wdt_clear_cmd;

  // option fields by name
  logic source_select_bit;
  logic edge_select_bit;
  tmr_pkg::tmr_pre_user_t scaler_assign_bit;
  logic [2:0] scale_ratio_field;

  // true when the data phase writes the given register
  function automatic logic wr_to(input logic en, input logic [7:0] idx,
                                 input logic [7:0] want);
    wr_to = en && (idx == want);
  endfunction

  // prescaler terminal mask from ratio field and owner
  function automatic logic [7:0] ratio_mask(input logic [2:0] ps,
                                            input tmr_pkg::tmr_pre_user_t user);
    logic [8:0] ratio;
    ratio = 9'h000;
    if (user == tmr_pkg::TMR_PRE_COUNTER) begin
      ratio = 9'h002 << ps;
    end else begin
      ratio = 9'h001 << ps;
    end
    ratio_mask = 8'((ratio - 9'h001) & 9'h0ff);
  endfunction

  assign source_select_bit = option_config[`TMR_OPT_SOURCE_SELECT];
  assign edge_select_bit = option_config[`TMR_OPT_EDGE_SELECT];
  assign scaler_assign_bit = tmr_pkg::tmr_pre_user_t'(option_config[`TMR_OPT_SCALER_ASSIGN]);
  assign scale_ratio_field = option_config[`TMR_OPT_RATIO_HI:`TMR_OPT_RATIO_LO];

  // address phase accepted only while the slave is idle
  assign addr_take = (bus_st == tmr_pkg::TMR_BUS_IDLE) && hsel && htrans[1] && hready;

  // bus phase tracking: one wait state on every transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st <= tmr_pkg::TMR_BUS_IDLE;
      hreadyout <= 1'b1;
    end else begin
      unique case (bus_st)
        tmr_pkg::TMR_BUS_IDLE: begin
          if (addr_take) begin
            bus_st <= tmr_pkg::TMR_BUS_DATA;
            hreadyout <= 1'b0;
          end
        end
        tmr_pkg::TMR_BUS_DATA: begin
          bus_st <= tmr_pkg::TMR_BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // address phase capture, held through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_idx <= 8'h00;
      cur_write <= 1'b0;
      cur_hit <= 1'b0;
    end else if (addr_take) begin
      cur_idx <= haddr[9:2];
      cur_write <= hwrite;
      cur_hit <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0); // misaligned reads 0
    end
  end

  // writes act at the end of the data phase, low byte only
  assign wr_en = (bus_st == tmr_pkg::TMR_BUS_DATA) && cur_write && cur_hit;
  assign wr_byte = hwdata[7:0];

  // one write strobe per register, decoded once
  assign wr_option = wr_to(wr_en, cur_idx, `TMR_IDX_OPTION_CONFIG);
  assign wr_dir = wr_to(wr_en, cur_idx, `TMR_IDX_PORT_A_DIRECTION);
  assign wr_enable = wr_to(wr_en, cur_idx, `TMR_IDX_EVT_ENABLE);
  assign wr_ctrl = wr_to(wr_en, cur_idx, `TMR_IDX_CORE_CTRL);
  assign wr_irqctl = wr_to(wr_en, cur_idx, `TMR_IDX_IRQ_CONTROL);
  assign wr_evtclr = wr_to(wr_en, cur_idx, `TMR_IDX_EVT_CLEAR);
  assign tick_write = wr_to(wr_en, cur_idx, `TMR_IDX_TICK_COUNT);
  assign wdt_clear_cmd = wr_to(wr_en, cur_idx, `TMR_IDX_CORE_CMD) && wr_byte[`TMR_CMD_WDT_CLEAR];

  // read mux; the prescaler has no address
  always_comb begin
    rd_val = 8'h00;
    if (cur_hit) begin
      unique case (cur_idx)
        `TMR_IDX_TICK_COUNT: rd_val = tick_count_reg;
        `TMR_IDX_IRQ_CONTROL: rd_val = irq_control_reg;
        `TMR_IDX_OPTION_CONFIG: rd_val = option_config;
        `TMR_IDX_PORT_A_DIRECTION: rd_val = {2'h0, port_a_direction};
        `TMR_IDX_EVT_STATUS: rd_val = {6'h00, evt_status};
        `TMR_IDX_EVT_ENABLE: rd_val = {6'h00, evt_enable};
        `TMR_IDX_CORE_CTRL: rd_val = {7'h00, sleep_mode};
        default: rd_val = 8'h00;
      endcase
    end
  end

  // read data and response
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (bus_st == tmr_pkg::TMR_BUS_DATA && !cur_write) begin
        hrdata <= {24'h000000, rd_val};
      end
    end
  end

  // option register; the prescaler owner may change at any time, count kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option_config <= `TMR_RST_OPTION_CONFIG;
    end else if (wr_option) begin
      option_config <= wr_byte;
    end
  end

  // port a direction bits, upper two bits not stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_direction <= `TMR_RST_PORT_A_DIRECTION;
    end else if (wr_dir) begin
      port_a_direction <= wr_byte[5:0];
    end
  end

  // event interrupt enables
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_enable <= '0;
    end else if (wr_enable) begin
      evt_enable <= wr_byte[`TMR_EVT_WIDTH-1:0];
    end
  end

  // sleep control; the watchdog path keeps running while asleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_mode <= 1'b0;
    end else if (wr_ctrl) begin
      sleep_mode <= wr_byte[`TMR_CTRL_SLEEP];
    end
  end

  // instruction cycle enable, stopped in sleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt <= 3'd0;
      icyc_en <= 1'b0;
    end else if (sleep_mode) begin
      div_cnt <= 3'd0;
      icyc_en <= 1'b0;
    end else begin
      icyc_en <= (div_cnt == `TMR_ICYC_CLOCKS - 3'd1);
      if (div_cnt == `TMR_ICYC_CLOCKS - 3'd1) begin
        div_cnt <= 3'd0;
      end else begin
        div_cnt <= div_cnt + 3'd1;
      end
    end
  end

  // external pin synchroniser and edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      ext_s1 <= ext_count_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // selected edge of the synchronised pin
  assign ext_edge = edge_select_bit ? (ext_s3 && !ext_s2) : (!ext_s3 && ext_s2);

  // hold-off after a counter write, in instruction cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inhibit_cnt <= 2'd0;
    end else if (tick_write) begin
      inhibit_cnt <= `TMR_WRITE_INHIBIT;
    end else if (icyc_en && inhibit_cnt != 2'd0) begin
      inhibit_cnt <= inhibit_cnt - 2'd1;
    end
  end

  // counting source: instruction cycles or pin edges
  assign src_evt = (source_select_bit ? ext_edge : icyc_en)
                   && !sleep_mode && (inhibit_cnt == 2'd0);

  // shared prescaler input and terminal count
  assign pre_mask = ratio_mask(scale_ratio_field, scaler_assign_bit);
  assign pre_evt = (scaler_assign_bit == tmr_pkg::TMR_PRE_COUNTER) ? src_evt
                   : wdt_base_tick;
  assign pre_hit = pre_evt && ((prescaler & pre_mask) == pre_mask);
  assign cnt_step = (scaler_assign_bit == tmr_pkg::TMR_PRE_COUNTER) ? pre_hit : src_evt;
  assign wdt_evt = (scaler_assign_bit == tmr_pkg::TMR_PRE_WATCHDOG) && pre_hit;

  // prescaler count, cleared by its owner's clear event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescaler <= 8'h00;
    end else if (tick_write && scaler_assign_bit == tmr_pkg::TMR_PRE_COUNTER) begin
      prescaler <= 8'h00;
    end else if (wdt_clear_cmd && scaler_assign_bit == tmr_pkg::TMR_PRE_WATCHDOG) begin
      prescaler <= 8'h00;
    end else if (pre_hit) begin
      prescaler <= 8'h00;
    end else if (pre_evt) begin
      prescaler <= prescaler + 8'h01;
    end
  end

  // watchdog tick and clear pulses toward the watchdog
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_tick <= 1'b0;
      wdt_clear <= 1'b0;
    end else begin
      wdt_tick <= wdt_evt;
      wdt_clear <= wdt_clear_cmd;
    end
  end

  // the counter itself; a write wins over a step
  assign ovf_evt = cnt_step && !tick_write && (tick_count_reg == `TMR_COUNT_MAX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_count_reg <= `TMR_RST_TICK_COUNT;
    end else if (tick_write) begin
      tick_count_reg <= wr_byte;
    end else if (cnt_step) begin
      tick_count_reg <= tick_count_reg + 8'h01;
    end
  end

  // interrupt control; hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_control_reg <= `TMR_RST_IRQ_CONTROL;
    end else begin
      if (wr_irqctl) begin
        irq_control_reg <= wr_byte;
      end
      if (ovf_evt) begin
        irq_control_reg[`TMR_IRQ_OVF_FLAG] <= 1'b1;
      end
    end
  end

  // sticky event status with write-one-to-clear register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_status <= '0;
    end else begin
      for (int i = 0; i < `TMR_EVT_WIDTH; i++) begin
        if ((i == `TMR_EVT_OVERFLOW && ovf_evt) || (i == `TMR_EVT_WDT_TICK && wdt_evt)) begin
          evt_status[i] <= 1'b1;
        end else if (wr_evtclr && wr_byte[i]) begin
          evt_status[i] <= 1'b0;
        end
      end
    end
  end

  // interrupt outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_irq <= 1'b0;
      irq <= 1'b0;
    end else begin
      overflow_irq <= irq_control_reg[`TMR_IRQ_OVF_FLAG]
                      && irq_control_reg[`TMR_IRQ_OVF_ENABLE];
      irq <= |(evt_status & evt_enable);
    end
  end

endmodule

`default_nettype wire

// File: tmr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic [3:0] toggles, // pin edges to make
  input wire logic go, // start a burst of edges
  output logic ext_count_pin, // external count input
  output logic wdt_base_tick // watchdog time base pulse
);
  logic [3:0] left;
  logic [2:0] gap;
  logic [1:0] base;
  // pin edges eight clocks apart; the level holds between bursts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left <= 4'h0;
      gap <= 3'h0;
      ext_count_pin <= 1'b0;
    end else if (go) begin
      left <= toggles;
      gap <= 3'h0;
    end else if (left != 4'h0) begin
      gap <= gap + 3'h1;
      if (gap == 3'h7) begin
        ext_count_pin <= !ext_count_pin;
        left <= left - 4'h1;
      end
    end
  end
  // free running time base, one pulse every four clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      base <= 2'h0;
    end else begin
      base <= base + 2'h1;
    end
  end
  assign wdt_base_tick = (base == 2'h3);
endmodule
`default_nettype wire

// File: tmr_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_top_sva (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hready, // bus ready
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // slave ready
  input wire logic hresp, // response
  input wire logic wdt_base_tick, // time base pulse
  input wire logic wdt_tick, // prescaled tick
  input wire logic wdt_clear, // clear pulse
  input wire logic overflow_irq, // overflow request
  input wire logic irq, // event request
  input wire logic [5:0] port_a_direction // direction bits
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // bus answers with one wait state, okay, upper bits zero
  property p_wait; hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout; endproperty
  a_wait: assert property (p_wait) else $error("wait state not one cycle");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_upper; hrdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  // watchdog side pulses
  property p_clr; $rose(wdt_clear) |-> (!$past(hreadyout) || !$past(hreadyout, 2)) ##1 !wdt_clear; endproperty
  a_clr: assert property (p_clr) else $error("stray watchdog clear");
  property p_tick; wdt_tick |-> $past(wdt_base_tick) || $past(wdt_base_tick, 2); endproperty
  a_tick: assert property (p_tick) else $error("tick without base pulse");
  // direction changes and request drops only after a bus write
  property p_dir; !$stable(port_a_direction) |-> !$past(hreadyout); endproperty
  a_dir: assert property (p_dir) else $error("direction changed alone");
  property p_ovf; $fell(overflow_irq) |-> !$past(hreadyout, 2); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow request dropped alone");
  property p_irq; $fell(irq) |-> !$past(hreadyout, 2); endproperty
  a_irq: assert property (p_irq) else $error("event request dropped alone");
endmodule
bind tmr_top tmr_top_sva u_sva (.hclk, .hresetn, .hsel, .htrans, .hready, .hrdata, .hreadyout,
  .hresp, .wdt_base_tick, .wdt_tick, .wdt_clear, .overflow_irq, .irq, .port_a_direction);
`default_nettype wire

// File: test_eight_bit_timer_with_shared_prescaler.sv
`include "tmr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_eight_bit_timer_with_shared_prescaler;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, ext_count_pin, wdt_base_tick, wdt_tick, wdt_clear, overflow_irq, irq;
  logic [5:0] port_a_direction;
  logic go = 1'b0;
  logic [3:0] toggles = 4'h0;
  int err_count = 0;
  int samples_checked = 0;
  int ticks = 0;
  int clears = 0;
  int r, t0, c0;

  always #25 hclk = !hclk;

  tmr_top dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_count_pin, .wdt_base_tick,
    .wdt_tick, .wdt_clear, .overflow_irq, .irq, .port_a_direction);
  tmr_pin_model pins (.hclk, .hresetn, .toggles, .go, .ext_count_pin, .wdt_base_tick);

  // count watchdog ticks and clear pulses
  always @(posedge hclk) begin
    ticks <= ticks + int'(wdt_tick === 1'b1);
    clears <= clears + int'(wdt_clear === 1'b1);
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] lo, hi, got);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("BAD %s expected %0h..%0h seen %0h", what, lo, hi, got);
    end
  endtask

  // one single transfer: address phase, then data phase until ready
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    haddr <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string what, input logic [7:0] idx, lo, hi);
    xfer(idx, 1'b0, 8'h00);
    chk(what, lo, hi, rd[7:0]);
  endtask

  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    close_out();
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, narrow register, unmapped and read-only places
    rchk("tick", `TMR_IDX_TICK_COUNT, 8'h00, 8'h00);
    rchk("intc", `TMR_IDX_IRQ_CONTROL, 8'h00, 8'h00);
    rchk("opt", `TMR_IDX_OPTION_CONFIG, 8'hff, 8'hff);
    rchk("dir", `TMR_IDX_PORT_A_DIRECTION, 8'h3f, 8'h3f);
    xfer(`TMR_IDX_PORT_A_DIRECTION, 1'b1, 8'hd5);
    rchk("dir", `TMR_IDX_PORT_A_DIRECTION, 8'h15, 8'h15);
    chk("dir pins", 8'h15, 8'h15, {2'h0, port_a_direction});
    xfer(8'h40, 1'b1, 8'h77);
    rchk("unmapped", 8'h40, 8'h00, 8'h00);
    xfer(`TMR_IDX_EVT_STATUS, 1'b1, 8'h03);
    rchk("status", `TMR_IDX_EVT_STATUS, 8'h00, 8'h00);
    // timer mode with the prescaler on the watchdog
    xfer(`TMR_IDX_OPTION_CONFIG, 1'b1, 8'h0a);
    xfer(`TMR_IDX_TICK_COUNT, 1'b1, 8'h10);
    rchk("held", `TMR_IDX_TICK_COUNT, 8'h10, 8'h10);
    repeat (32) @(posedge hclk);
    rchk("run", `TMR_IDX_TICK_COUNT, 8'h17, 8'h18);
    // prescaler on the counter, every ratio; owner moved first so no late tick counts
    xfer(`TMR_IDX_OPTION_CONFIG, 1'b1, 8'h00);
    repeat (2) @(posedge hclk);
    t0 = ticks;
    for (int ps = 0; ps < 8; ps++) begin
      r = 2 << ps;
      xfer(`TMR_IDX_OPTION_CONFIG, 1'b1, 8'(ps));
      xfer(`TMR_IDX_TICK_COUNT, 1'b1, 8'h00);
      repeat (4 * (3 * r + r / 2 + 2) - 5) @(posedge hclk);
      rchk("scaled", `TMR_IDX_TICK_COUNT, 8'h03, 8'h03);
      rchk("kept", `TMR_IDX_OPTION_CONFIG, 8'(ps), 8'(ps));
    end
    chk("wdt idle", 8'h00, 8'h00, 8'(ticks - t0));
    // prescaler moved back to the watchdog, every ratio
    c0 = clears;
    for (int ps = 0; ps < 8; ps++) begin
      r = 1 << ps;
      xfer(`TMR_IDX_TICK_COUNT, 1'b1, 8'h00);
      xfer(`TMR_IDX_OPTION_CONFIG, 1'b1, 8'h08 | 8'(ps));
      xfer(`TMR_IDX_CORE_CMD, 1'b1, 8'h01);
      @(posedge hclk);
      t0 = ticks;
      repeat (18 * r) @(posedge hclk);
      chk("wdt ticks", 8'h04, r == 1 ? 8'h05 : 8'h04, 8'(ticks - t0));
    end
    chk("clears", 8'h08, 8'h08, 8'(clears - c0));
    // pin edges, rising then falling selected
    for (int i = 0; i < 2; i++) begin
      xfer(`TMR_IDX_OPTION_CONFIG, 1'b1, 8'h28 | 8'(i << 4));
      xfer(`TMR_IDX_TICK_COUNT, 1'b1, 8'h00);
      repeat (16) @(posedge hclk);
      toggles <= 4'h3;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      repeat (40) @(posedge hclk);
      rchk("edges", `TMR_IDX_TICK_COUNT, 8'h02, 8'h02);
    end
    // sleep stops the timer
    xfer(`TMR_IDX_OPTION_CONFIG, 1'b1, 8'h08);
    xfer(`TMR_IDX_CORE_CTRL, 1'b1, 8'h01);
    xfer(`TMR_IDX_TICK_COUNT, 1'b1, 8'h40);
    repeat (40) @(posedge hclk);
    rchk("asleep", `TMR_IDX_TICK_COUNT, 8'h40, 8'h40);
    xfer(`TMR_IDX_CORE_CTRL, 1'b1, 8'h00);
    // rollover: masked, enabled, cleared; event interrupt raised and cleared
    xfer(`TMR_IDX_TICK_COUNT, 1'b1, 8'hfe);
    repeat (24) @(posedge hclk);
    rchk("flag", `TMR_IDX_IRQ_CONTROL, 8'h04, 8'h04);
    chk("masked", 8'h00, 8'h00, {6'h0, irq, overflow_irq});
    xfer(`TMR_IDX_IRQ_CONTROL, 1'b1, 8'h24);
    @(posedge hclk);
    chk("request", 8'h01, 8'h01, {7'h0, overflow_irq});
    xfer(`TMR_IDX_IRQ_CONTROL, 1'b1, 8'h20);
    @(posedge hclk);
    chk("flag clear", 8'h00, 8'h00, {7'h0, overflow_irq});
    xfer(`TMR_IDX_EVT_ENABLE, 1'b1, 8'h01);
    @(posedge hclk);
    chk("irq", 8'h01, 8'h01, {7'h0, irq});
    xfer(`TMR_IDX_EVT_CLEAR, 1'b1, 8'h01);
    @(posedge hclk);
    chk("irq clear", 8'h00, 8'h00, {7'h0, irq});
    xfer(`TMR_IDX_EVT_STATUS, 1'b0, 8'h00);
    chk("status", 8'h00, 8'h00, {7'h0, rd[0]});
    close_out();
  end
endmodule
`default_nettype wire
